/* File: hdlc_regs_pkg.sv */
package hdlc_regs_pkg;

    localparam int ADDR_W = 5;
    localparam int DATA_W = 8;
    localparam int FIFO_CNT_W = 8;

    // register addresses
    localparam logic [4:0] ADDR_FIFO_STATUS = 5'h14;
    localparam logic [4:0] ADDR_CONTROL_TWO = 5'h15;
    localparam logic [4:0] ADDR_INT_MASK = 5'h16;
    localparam logic [4:0] ADDR_INT_FLAGS = 5'h17;

    // reset values
    localparam logic [7:0] CONTROL_TWO_RST = 8'h00;
    localparam logic [7:0] INT_MASK_RST = 8'h00;
    localparam logic [7:0] INT_FLAGS_RST = 8'h00;

    // control register two fields
    localparam int CT_INTSEL_BIT = 7;
    localparam int CT_CYCLE_BIT = 6;
    localparam int CT_CRC_INHIBIT_BIT = 5;
    localparam int CT_SEVEN_BIT = 4;
    localparam int CT_RX_FIFO_RST_BIT = 1;
    localparam int CT_TX_FIFO_RST_BIT = 0;

    // interrupt flag positions
    localparam int IF_GO_AHEAD = 7;
    localparam int IF_RX_END = 6;
    localparam int IF_TX_DONE = 5;
    localparam int IF_LAST_READ = 4;
    localparam int IF_TX_LOW = 3;
    localparam int IF_ABORT_UNDER = 2;
    localparam int IF_RX_FULL = 1;
    localparam int IF_RX_OVFL = 0;

    // status register fields
    localparam int ST_INTGEN_BIT = 7;
    localparam int ST_TX_LO_BIT = 2;
    localparam int ST_RX_LO_BIT = 0;

    // fifo status encodings
    localparam logic [1:0] RX_ST_EMPTY = 2'h0;
    localparam logic [1:0] RX_ST_BELOW = 2'h1;
    localparam logic [1:0] RX_ST_FULL_LVL = 2'h2;
    localparam logic [1:0] RX_ST_INT_LVL = 2'h3;
    localparam logic [1:0] TX_ST_FULL_LVL = 2'h0;
    localparam logic [1:0] TX_ST_INT_LVL = 2'h1;
    localparam logic [1:0] TX_ST_EMPTY = 2'h2;
    localparam logic [1:0] TX_ST_BELOW = 2'h3;

    localparam int RX_FIFO_DEPTH = 128;
    localparam int ABORT_MIN_BITS = 26;

    typedef struct packed {
        logic go_ahead_seen;
        logic rx_eop_written;
        logic tx_packet_done;
        logic last_byte_pending_read;
        logic rx_abort;
        logic rx_bit;
        logic rx_flag;
        logic rx_write;
        logic rx_read;
        logic tx_fetch;
        logic tx_write;
    } dp_events_s;

    typedef struct packed {
        logic [7:0] rx_count;
        logic [7:0] tx_count;
        logic [7:0] rx_int_level;
        logic [7:0] rx_status_level;
        logic [7:0] tx_int_level;
        logic [7:0] tx_status_level;
    } fifo_levels_s;

    typedef struct packed {
        logic rx_enable;
        logic rx_fifo_flush;
        logic tx_fifo_flush;
        logic crc_inhibit;
        logic seven_bit_addr;
        logic cycle_count;
    } dp_ctrl_s;

endpackage

/* File: level_compare.sv */
`timescale 1ns/100ps
// turns a fifo fill count into empty and level flags and rising and falling interrupt level crossings
module level_compare #(
    parameter int W = 8
) (
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic [W-1:0] count_in,
    input wire logic [W-1:0] int_level_in,
    input wire logic [W-1:0] status_level_in,
    input wire logic force_empty_in,
    output logic empty_out,
    output logic at_int_out,
    output logic at_status_out,
    output logic int_cross_up_out,
    output logic int_cross_down_out
);

    logic at_int_q;

    always_comb
    begin
        empty_out = force_empty_in || (count_in == '0);
        at_int_out = !empty_out && (count_in >= int_level_in);
        at_status_out = !empty_out && (count_in >= status_level_in);
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (!rst_n_in)
            at_int_q <= 1'b0;
        else
            at_int_q <= at_int_out;
    end

    assign int_cross_up_out = at_int_out && !at_int_q;
    assign int_cross_down_out = !at_int_out && at_int_q;

endmodule

/* File: hdlc_fifo_ctrl_irq_regs.sv */
`timescale 1ns/100ps
module hdlc_fifo_ctrl_irq_regs (
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic [4:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [7:0] rdata_out,
    input wire hdlc_regs_pkg::dp_events_s events_in,
    input wire hdlc_regs_pkg::fifo_levels_s levels_in,
    output hdlc_regs_pkg::dp_ctrl_s ctrl_out,
    output logic [7:0] tx_count_value_out,
    input wire logic [7:0] tx_count_load_in,
    input wire logic tx_count_load_wr_in,
    output logic tx_tag_eop_out,
    output logic irq_n_out
);

    logic [7:0] control_two_q;
    logic [7:0] int_mask_q;
    logic [7:0] int_flags_q;
    logic [7:0] int_flags_d;
    logic intgen_q;
    logic rx_flush_q;
    logic rx_ovfl_block_q;
    logic [4:0] rx_bit_cnt_q;
    logic rx_in_packet_q;
    logic [7:0] tx_count_q;
    logic [7:0] tx_count_reload_q;
    logic [7:0] event_vec;
    logic flags_read;
    logic ct_write;
    logic rx_empty;
    logic rx_at_int;
    logic rx_at_status;
    logic rx_up;
    logic tx_empty;
    logic tx_at_int;
    logic tx_at_status;
    logic tx_down;
    logic rx_full;
    logic [1:0] rx_code;
    logic [1:0] tx_code;
    logic [7:0] status_val;

    assign flags_read = rd_in && (addr_in == hdlc_regs_pkg::ADDR_INT_FLAGS);
    assign ct_write = wr_in && (addr_in == hdlc_regs_pkg::ADDR_CONTROL_TWO);

    level_compare #(
        .W(8)
    ) u_rx_level (
        .clk_sys_in(clk_sys_in),
        .rst_n_in(rst_n_in),
        .count_in(levels_in.rx_count),
        .int_level_in(levels_in.rx_int_level),
        .status_level_in(levels_in.rx_status_level),
        .force_empty_in(rx_flush_q),
        .empty_out(rx_empty),
        .at_int_out(rx_at_int),
        .at_status_out(rx_at_status),
        .int_cross_up_out(rx_up),
        .int_cross_down_out()
    );

    level_compare #(
        .W(8)
    ) u_tx_level (
        .clk_sys_in(clk_sys_in),
        .rst_n_in(rst_n_in),
        .count_in(levels_in.tx_count),
        .int_level_in(levels_in.tx_int_level),
        .status_level_in(levels_in.tx_status_level),
        .force_empty_in(control_two_q[hdlc_regs_pkg::CT_TX_FIFO_RST_BIT]),
        .empty_out(tx_empty),
        .at_int_out(tx_at_int),
        .at_status_out(tx_at_status),
        .int_cross_up_out(),
        .int_cross_down_out(tx_down)
    );

    assign rx_full = !rx_flush_q && (levels_in.rx_count >= 8'(hdlc_regs_pkg::RX_FIFO_DEPTH));

    // control register two
    always_ff @(posedge clk_sys_in)
    begin
        if (!rst_n_in)
            control_two_q <= hdlc_regs_pkg::CONTROL_TWO_RST;
        else if (ct_write)
            control_two_q <= wdata_in;
        else if (events_in.tx_write)
            control_two_q[hdlc_regs_pkg::CT_TX_FIFO_RST_BIT] <= 1'b0;
    end

    // mask register
    always_ff @(posedge clk_sys_in)
    begin
        if (!rst_n_in)
            int_mask_q <= hdlc_regs_pkg::INT_MASK_RST;
        else if (wr_in && (addr_in == hdlc_regs_pkg::ADDR_INT_MASK))
            int_mask_q <= wdata_in;
    end

    // rx fifo reset holds empty view until the next flag
    always_ff @(posedge clk_sys_in)
    begin
        if (!rst_n_in)
            rx_flush_q <= 1'b0;
        else if (ct_write && wdata_in[hdlc_regs_pkg::CT_RX_FIFO_RST_BIT])
            rx_flush_q <= 1'b1;
        else if (events_in.rx_flag)
            rx_flush_q <= 1'b0;
    end

    // overflow blocks the receiver until the next flag
    always_ff @(posedge clk_sys_in)
    begin
        if (!rst_n_in)
            rx_ovfl_block_q <= 1'b0;
        else if (events_in.rx_write && rx_full)
            rx_ovfl_block_q <= 1'b1;
        else if (events_in.rx_flag)
            rx_ovfl_block_q <= 1'b0;
    end

    // received bit count within a packet, saturating at the abort minimum
    always_ff @(posedge clk_sys_in)
    begin
        if (!rst_n_in)
        begin
            rx_bit_cnt_q <= 5'h0;
            rx_in_packet_q <= 1'b0;
        end
        else if (events_in.rx_flag || events_in.rx_abort)
        begin
            rx_bit_cnt_q <= 5'h0;
            rx_in_packet_q <= events_in.rx_flag;
        end
        else if (events_in.rx_bit && rx_in_packet_q && (rx_bit_cnt_q < 5'(hdlc_regs_pkg::ABORT_MIN_BITS)))
            rx_bit_cnt_q <= rx_bit_cnt_q + 5'h1;
    end

    // transmit byte counter with cyclic reload
    always_ff @(posedge clk_sys_in)
    begin
        if (!rst_n_in)
        begin
            tx_count_q <= 8'h00;
            tx_count_reload_q <= 8'h00;
        end
        else if (tx_count_load_wr_in)
        begin
            tx_count_q <= tx_count_load_in;
            tx_count_reload_q <= tx_count_load_in;
        end
        else if (events_in.tx_write && (tx_count_q != 8'h00))
        begin
            if ((tx_count_q == 8'h01) && control_two_q[hdlc_regs_pkg::CT_CYCLE_BIT])
                tx_count_q <= tx_count_reload_q;
            else
                tx_count_q <= tx_count_q - 8'h01;
        end
    end

    assign tx_count_value_out = tx_count_q;
    assign tx_tag_eop_out = (tx_count_q == 8'h01);

    // events feeding the flag register
    always_comb
    begin
        event_vec = 8'h00;
        event_vec[hdlc_regs_pkg::IF_GO_AHEAD] = events_in.go_ahead_seen;
        event_vec[hdlc_regs_pkg::IF_RX_END] = events_in.rx_eop_written;
        event_vec[hdlc_regs_pkg::IF_TX_DONE] = events_in.tx_packet_done;
        event_vec[hdlc_regs_pkg::IF_LAST_READ] = events_in.last_byte_pending_read
            || (events_in.rx_read && rx_empty);
        event_vec[hdlc_regs_pkg::IF_TX_LOW] = tx_down;
        if (control_two_q[hdlc_regs_pkg::CT_INTSEL_BIT])
            event_vec[hdlc_regs_pkg::IF_ABORT_UNDER] = events_in.tx_fetch && tx_empty;
        else
            event_vec[hdlc_regs_pkg::IF_ABORT_UNDER] = events_in.rx_abort && rx_in_packet_q
                && (rx_bit_cnt_q >= 5'(hdlc_regs_pkg::ABORT_MIN_BITS));
        event_vec[hdlc_regs_pkg::IF_RX_FULL] = rx_up;
        event_vec[hdlc_regs_pkg::IF_RX_OVFL] = events_in.rx_write && rx_full;
    end

    // flags: read clears, a same-cycle event wins
    always_comb
    begin
        int_flags_d = flags_read ? 8'h00 : int_flags_q;
        int_flags_d = int_flags_d | event_vec;
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (!rst_n_in)
            int_flags_q <= hdlc_regs_pkg::INT_FLAGS_RST;
        else
            int_flags_q <= int_flags_d;
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (!rst_n_in)
            intgen_q <= 1'b0;
        else if ((event_vec & int_mask_q) != 8'h00)
            intgen_q <= 1'b1;
        else if (flags_read)
            intgen_q <= 1'b0;
    end

    assign irq_n_out = !((int_flags_q & int_mask_q) != 8'h00);

    // fifo status codes
    always_comb
    begin
        if (rx_empty)
            rx_code = hdlc_regs_pkg::RX_ST_EMPTY;
        else if (rx_at_int)
            rx_code = hdlc_regs_pkg::RX_ST_INT_LVL;
        else if (rx_at_status)
            rx_code = hdlc_regs_pkg::RX_ST_FULL_LVL;
        else
            rx_code = hdlc_regs_pkg::RX_ST_BELOW;
        if (tx_empty)
            tx_code = hdlc_regs_pkg::TX_ST_EMPTY;
        else if (tx_at_status)
            tx_code = hdlc_regs_pkg::TX_ST_FULL_LVL;
        else if (tx_at_int)
            tx_code = hdlc_regs_pkg::TX_ST_INT_LVL;
        else
            tx_code = hdlc_regs_pkg::TX_ST_BELOW;
        status_val = 8'h00;
        status_val[hdlc_regs_pkg::ST_INTGEN_BIT] = intgen_q;
        status_val[hdlc_regs_pkg::ST_TX_LO_BIT +: 2] = tx_code;
        status_val[hdlc_regs_pkg::ST_RX_LO_BIT +: 2] = rx_code;
    end

    // read data register
    always_ff @(posedge clk_sys_in)
    begin
        if (!rst_n_in)
            rdata_out <= 8'h00;
        else if (rd_in)
        begin
            unique case (addr_in)
                hdlc_regs_pkg::ADDR_FIFO_STATUS: rdata_out <= status_val;
                hdlc_regs_pkg::ADDR_CONTROL_TWO: rdata_out <= control_two_q;
                hdlc_regs_pkg::ADDR_INT_MASK: rdata_out <= int_mask_q;
                hdlc_regs_pkg::ADDR_INT_FLAGS: rdata_out <= int_flags_q;
                default: rdata_out <= 8'h00;
            endcase
        end
    end

    // controls toward the datapaths
    always_comb
    begin
        ctrl_out.rx_enable = !rx_flush_q && !rx_ovfl_block_q;
        ctrl_out.rx_fifo_flush = rx_flush_q;
        ctrl_out.tx_fifo_flush = control_two_q[hdlc_regs_pkg::CT_TX_FIFO_RST_BIT];
        ctrl_out.crc_inhibit = control_two_q[hdlc_regs_pkg::CT_CRC_INHIBIT_BIT];
        ctrl_out.seven_bit_addr = control_two_q[hdlc_regs_pkg::CT_SEVEN_BIT];
        ctrl_out.cycle_count = control_two_q[hdlc_regs_pkg::CT_CYCLE_BIT];
    end

endmodule

/* File: dp_model.sv */
`timescale 1ns/100ps
// behavioural datapath side: fifo fill counts and fixed thresholds
module dp_model (
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire hdlc_regs_pkg::dp_events_s ev_in,
    output hdlc_regs_pkg::fifo_levels_s levels_out
);
    logic [7:0] rx_q;
    logic [7:0] tx_q;
    always_ff @(posedge clk_sys_in)
    begin
        if (!rst_n_in)
        begin
            rx_q <= 8'h00;
            tx_q <= 8'h00;
        end
        else
        begin
            if (ev_in.rx_write && rx_q < 8'h80)
                rx_q <= rx_q + 8'h01;
            else if (ev_in.rx_read && rx_q != 8'h00)
                rx_q <= rx_q - 8'h01;
            if (ev_in.tx_write)
                tx_q <= tx_q + 8'h01;
            else if (ev_in.tx_fetch && tx_q != 8'h00)
                tx_q <= tx_q - 8'h01;
        end
    end
    assign levels_out = {rx_q, tx_q, 8'h60, 8'h40, 8'h08, 8'h10};
endmodule

/* File: hdlc_fifo_ctrl_irq_regs_properties.sv */
`timescale 1ns/100ps
module hdlc_checker (
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic [4:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic [7:0] rdata_out,
    input wire hdlc_regs_pkg::dp_events_s events_in,
    input wire hdlc_regs_pkg::fifo_levels_s levels_in,
    input wire hdlc_regs_pkg::dp_ctrl_s ctrl_out,
    input wire logic irq_n_out
);
    logic [7:0] mask_q;
    logic wr_ct;
    assign wr_ct = wr_in && addr_in == hdlc_regs_pkg::ADDR_CONTROL_TWO;
    always_ff @(posedge clk_sys_in)
    begin
        if (!rst_n_in)
            mask_q <= 8'h00;
        else if (wr_in && addr_in == hdlc_regs_pkg::ADDR_INT_MASK)
            mask_q <= wdata_in;
    end
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!rst_n_in);
    property p_cycle; wr_ct |=> ctrl_out.cycle_count == $past(wdata_in[6]); endproperty
    a_cycle: assert property (p_cycle) else $error("cycle bit not applied");
    property p_crc; wr_ct |=> ctrl_out.crc_inhibit == $past(wdata_in[5]); endproperty
    a_crc: assert property (p_crc) else $error("crc inhibit not applied");
    property p_seven; wr_ct |=> ctrl_out.seven_bit_addr == $past(wdata_in[4]); endproperty
    a_seven: assert property (p_seven) else $error("seven bit mode not applied");
    property p_rx_flush; wr_ct && wdata_in[1] && !events_in.rx_flag |=> !ctrl_out.rx_enable; endproperty
    a_rx_flush: assert property (p_rx_flush) else $error("receiver kept on after flush");
    property p_ovfl;
        events_in.rx_write && levels_in.rx_count >= 8'h80 && !ctrl_out.rx_fifo_flush && !events_in.rx_flag
        |=> !ctrl_out.rx_enable;
    endproperty
    a_ovfl: assert property (p_ovfl) else $error("receiver kept on after overflow");
    property p_masked; mask_q == 8'h00 |-> irq_n_out; endproperty
    a_masked: assert property (p_masked) else $error("request with all masked");
    property p_unmasked; events_in.go_ahead_seen && mask_q[7] |=> !irq_n_out; endproperty
    a_unmasked: assert property (p_unmasked) else $error("no request on unmasked event");
    property p_clear;
        rd_in && addr_in == hdlc_regs_pkg::ADDR_INT_FLAGS && events_in == '0 && $stable(levels_in) |=> irq_n_out;
    endproperty
    a_clear: assert property (p_clear) else $error("request kept after flag read");
    property p_rx_empty;
        rd_in && addr_in == hdlc_regs_pkg::ADDR_FIFO_STATUS && levels_in.rx_count == 8'h00 && $stable(levels_in)
        |=> rdata_out[1:0] == hdlc_regs_pkg::RX_ST_EMPTY;
    endproperty
    a_rx_empty: assert property (p_rx_empty) else $error("rx status not empty");
endmodule
bind hdlc_fifo_ctrl_irq_regs hdlc_checker chk (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .events_in(events_in),
    .levels_in(levels_in), .ctrl_out(ctrl_out), .irq_n_out(irq_n_out));

/* File: tb_hdlc_fifo_ctrl_irq_regs.sv */
`timescale 1ns/100ps
module tb_hdlc_fifo_ctrl_irq_regs;
    localparam logic [4:0] A_ST = hdlc_regs_pkg::ADDR_FIFO_STATUS;
    localparam logic [4:0] A_CT = hdlc_regs_pkg::ADDR_CONTROL_TWO;
    localparam logic [4:0] A_MK = hdlc_regs_pkg::ADDR_INT_MASK;
    localparam logic [4:0] A_FL = hdlc_regs_pkg::ADDR_INT_FLAGS;
    logic clk_sys_in;
    logic rst_n_in = 1'b0;
    logic [4:0] addr = 5'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] rdata;
    hdlc_regs_pkg::dp_events_s ev = '0;
    hdlc_regs_pkg::fifo_levels_s lv;
    hdlc_regs_pkg::dp_ctrl_s ctrl;
    logic [7:0] cnt;
    logic [7:0] ld = 8'h00;
    logic ld_wr = 1'b0;
    logic eop;
    logic irq_n;
    int num_errors = 0;
    int n_compared = 0;
    logic [7:0] v;
    logic [7:0] r;
    int i;
    hdlc_fifo_ctrl_irq_regs uut (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .addr_in(addr), .wdata_in(wdata),
        .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .events_in(ev), .levels_in(lv), .ctrl_out(ctrl),
        .tx_count_value_out(cnt), .tx_count_load_in(ld), .tx_count_load_wr_in(ld_wr), .tx_tag_eop_out(eop),
        .irq_n_out(irq_n));
    dp_model dp (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .ev_in(ev), .levels_out(lv));
    initial
    begin
        clk_sys_in = 1'b0;
        forever #5 clk_sys_in = ~clk_sys_in;
    end
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic results();
        $display("errors %0d compared %0d", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic wr_reg(input logic [4:0] a, input logic [7:0] d);
        @(posedge clk_sys_in);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_sys_in);
        wr <= 1'b0;
        #1;
    endtask
    task automatic rd_reg(input logic [4:0] a);
        repeat (2) @(posedge clk_sys_in);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_sys_in);
        rd <= 1'b0;
        #1 v = rdata;
    endtask
    task automatic pulse(input logic [10:0] e);
        @(posedge clk_sys_in);
        ev <= e;
        @(posedge clk_sys_in);
        ev <= '0;
        #1;
    endtask
    // expected rx status code for a fill count
    function automatic logic [7:0] rx_code(input int c);
        return (c == 0) ? 8'h00 : (c >= 96) ? 8'h03 : (c >= 64) ? 8'h02 : 8'h01;
    endfunction
    initial
    begin
        #100000;
        num_errors++;
        results();
    end
    initial
    begin
        v = $urandom(32'h530b);
        repeat (10) @(posedge clk_sys_in);
        rst_n_in <= 1'b1;
        rd_reg(A_MK);
        check("mask", v, 8'h00);
        rd_reg(5'h10);
        check("unmapped", v, 8'h00);
        wr_reg(A_ST, 8'hff);
        rd_reg(A_ST);
        check("status", v & 8'h0f, 8'h08);
        for (i = 0; i < 8; i++)
        begin
            r = $urandom() & 8'hf0;
            wr_reg(A_CT, r);
            check("ctl", {5'h00, ctrl.cycle_count, ctrl.crc_inhibit, ctrl.seven_bit_addr}, r[6:4]);
            check("seven", ctrl.seven_bit_addr, r[4]);
            rd_reg(A_CT);
            check("ctl2", v, r);
        end
        wr_reg(A_CT, 8'h00);
        wr_reg(A_MK, 8'hf0);
        for (i = 0; i < 4; i++)
        begin
            pulse(11'h400 >> i);
            check("irq", irq_n, 8'h00);
            rd_reg(A_ST);
            check("intgen", v & 8'h80, 8'h80);
            rd_reg(A_FL);
            check("flags", v, 8'h80 >> i);
            check("irq", irq_n, 8'h01);
            rd_reg(A_ST);
            check("intgen", v & 8'h80, 8'h00);
        end
        wr_reg(A_MK, 8'h00);
        pulse(11'h400);
        check("irq", irq_n, 8'h01);
        rd_reg(A_ST);
        check("intgen", v & 8'h80, 8'h00);
        rd_reg(A_FL);
        check("flags", v, 8'h80);
        wr_reg(A_CT, 8'h40);
        @(posedge clk_sys_in);
        ld <= 8'h02;
        ld_wr <= 1'b1;
        @(posedge clk_sys_in);
        ld_wr <= 1'b0;
        pulse(11'h001);
        check("eop", eop, 8'h01);
        pulse(11'h001);
        check("count", cnt, 8'h02);
        wr_reg(A_CT, 8'h01);
        rd_reg(A_ST);
        check("txempty", v & 8'h0c, 8'h08);
        pulse(11'h001);
        check("txflush", ctrl.tx_fifo_flush, 8'h00);
        repeat (6) pulse(11'h001);
        rd_reg(A_FL);
        repeat (2) pulse(11'h002);
        rd_reg(A_FL);
        check("txlow", v, 8'h08);
        for (i = 0; i < 2; i++)
        begin
            pulse(11'h010);
            repeat (25 + i) pulse(11'h020);
            pulse(11'h040);
            rd_reg(A_FL);
            check("abort", v, (i == 1) ? 8'h04 : 8'h00);
        end
        wr_reg(A_CT, 8'h80);
        repeat (7) pulse(11'h002);
        rd_reg(A_FL);
        pulse(11'h002);
        rd_reg(A_FL);
        check("under", v, 8'h04);
        wr_reg(A_CT, 8'h00);
        for (i = 1; i <= 129; i++)
        begin
            pulse(11'h008);
            if (i % 32 == 0)
            begin
                rd_reg(A_ST);
                check("rxcode", v & 8'h03, rx_code(i));
            end
        end
        check("rxen", ctrl.rx_enable, 8'h00);
        rd_reg(A_FL);
        check("ovfl", v, 8'h03);
        pulse(11'h010);
        check("rxen", ctrl.rx_enable, 8'h01);
        wr_reg(A_CT, 8'h02);
        check("rxen", ctrl.rx_enable, 8'h00);
        check("rxflush", ctrl.rx_fifo_flush, 8'h01);
        rd_reg(A_ST);
        check("rxview", v & 8'h03, 8'h00);
        // software read while the flushed fifo shows empty
        pulse(11'h004);
        rd_reg(A_FL);
        check("emptyrd", v, 8'h10);
        pulse(11'h010);
        check("rxen", ctrl.rx_enable, 8'h01);
        check("rxflush", ctrl.rx_fifo_flush, 8'h00);
        // second reset in mid-run with a mask and a pending flag
        wr_reg(A_MK, 8'h5a);
        @(posedge clk_sys_in);
        rst_n_in <= 1'b0;
        repeat (10) @(posedge clk_sys_in);
        rst_n_in <= 1'b1;
        rd_reg(A_MK);
        check("mask", v, 8'h00);
        rd_reg(A_CT);
        check("ctl", v, 8'h00);
        check("irq", irq_n, 8'h01);
        results();
    end
endmodule
